// *** design/acc_clk_div.sv ***
`timescale 1ns/1ns
module acc_clk_div import acc_pkg::*; (
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   input  wire logic       clk_en_in,
   input  wire logic       clear_in,
   input  wire logic       tick_in,
   input  wire logic [1:0] sel_in,
   output logic            tick_out
);
   typedef struct packed {
      logic [2:0] cnt;   // source ticks seen
      logic       tick;  // converter clock enable
   } acc_div_t;

   acc_div_t   r;
   acc_div_t   n;
   logic [2:0] lim;      // last count before a tick

   // ****************************************
   // divide source ticks by 1, 2, 4 or 8
   // ****************************************
   always_comb begin
      n      = r;
      n.tick = 1'b0;
      lim    = 3'h0;
      unique case (sel_in)
         2'h0: lim = 3'h0;
         2'h1: lim = 3'h1;
         2'h2: lim = 3'h3;
         2'h3: lim = 3'h7;
      endcase
      // restart while idle so every conversion started from idle sees full periods
      if (clear_in) begin
         n.cnt = 3'h0;
      end else if (tick_in) begin
         if (r.cnt >= lim) begin
            n.cnt  = 3'h0;
            n.tick = 1'b1; // R12
         end else begin
            n.cnt = r.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r <= '0;
      end else if (clk_en_in) begin
         r <= n;
      end
   end

   assign tick_out = r.tick;

   AST_DIV_ONE: assert property (@(posedge clk_in) disable iff (srst_in || !clk_en_in)
      tick_in && !clear_in && sel_in == 2'h0 |=> tick_out) // R12
      else $error("divide by one lost a tick");
endmodule : acc_clk_div

// *** design/acc_conv_ctrl.sv ***
// Notes on behaviour
// R1: pin disable bit 1 turns port control off
// R2: disabled pin: driver off, pull-up off
// R3: disabled pin: input off, port reads zero
// R4: converter off in reset or channel all ones
// R5: idle in lowest power between conversions
// R6: ten-bit: round eleven bits into high/low
// R7: eight-bit: round nine bits into low only
// R8: transfer sets done; interrupt if enabled then
// R9: compare enable compares each result, all modes
// R10: four clock sources, bus clock after reset
// R11: async clock kept running when selected; code enables it only while converting
// R12: selected source divided by 1,2,4,8
// R13: hardware trigger rising edge starts conversion
// R14: trigger edge ignored while converting
// R15: continuous hardware mode: only first edge
// R16: control one write starts unless channel off; code also needs hardware trigger off
// R17: continuous mode restarts after each transfer
// R18: high read pending blocks transfer and flag
// R19: single, compare false: block moot, stop
// R20: other blocked transfers start another conversion
// R21: software waits for done before reading results
// R22: mode 00 eight-bit, 10 ten-bit
// R23: source codes bus, bus/2, alternate, async
// R24: control two/config/compare write aborts conversion
`timescale 1ns/1ns
`include "acc_defs.svh"
module acc_conv_ctrl import acc_pkg::*; #(
   parameter logic [5:0] TICKS_8  = `ACC_TICKS_8,  // converter clocks, eight-bit
   parameter logic [5:0] TICKS_10 = `ACC_TICKS_10  // converter clocks, ten-bit
) (
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   input  wire logic              clk_en_in,
   input  wire logic [`ACC_AW-1:0] avs_address_in,
   input  wire logic              avs_read_in,
   input  wire logic              avs_write_in,
   input  wire logic [31:0]       avs_writedata_in,
   input  wire logic [3:0]        avs_byteenable_in,
   output logic      [31:0]       avs_readdata_out,
   output logic                   avs_waitrequest_out,
   input  wire logic              alternate_clock_in,
   input  wire logic              async_conv_clock_in,
   input  wire logic              hw_trigger_input_in,
   input  wire logic [10:0]       analog_value_in,
   input  wire logic [23:0]       port_oe_in,
   input  wire logic [23:0]       port_pullup_in,
   input  wire logic [23:0]       pin_in,
   output logic      [23:0]       pad_oe_out,
   output logic      [23:0]       pad_pullup_out,
   output logic      [23:0]       port_read_out,
   output logic      [4:0]        channel_select_out,
   output logic                   conv_active_out,
   output logic                   async_clk_enable_out,
   output logic                   conv_irq_out
);
   // ****************************************
   // declarations
   // ****************************************
   acc_main_t   r;            // all state
   acc_main_t   n;            // next state
   logic [23:0] pin_q;        // synchronised pins
   logic [2:0]  ext;          // synced hw, async, alt
   logic [2:0]  rise;         // their rising edges
   logic        src_tick;     // selected source tick
   logic        conv_tick;    // converter_clock enable
   logic        req;          // bus request present
   logic        acc;          // request taken this edge
   logic        wr;           // register write taken
   logic        rd;           // register read taken
   logic [7:0]  wd;           // write byte
   logic        wsc1;
   logic        wsc2;
   logic        wcfg;
   logic        wcvh;
   logic        wcvl;
   logic        abort;        // write that kills a conversion
   logic [7:0]  rmux;         // read data mux
   logic [9:0]  v10;          // rounded ten-bit value
   logic [7:0]  v8;           // rounded eight-bit value
   logic [9:0]  val;          // value in current mode
   logic [9:0]  cmpv;         // compare value in current mode
   logic [9:0]  diff;         // result minus compare value
   logic        cond;         // compare condition true
   logic        pass;         // result may be transferred
   logic        blocked;      // split read in progress
   logic [5:0]  need;         // clocks per conversion
   logic        fin;          // conversion ends this edge
   logic        xfer;         // result lands this edge
   logic        restart;      // go on converting after fin
   logic        sw_start;
   logic        hw_start;
   logic [15:0] res16;        // value for result pair

   // ****************************************
   // input synchronisers
   // ****************************************
   acc_sync #(.WIDTH(24)) u_pin_sync (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .clk_en_in (clk_en_in),
      .d_in      (pin_in),
      .q_out     (pin_q)
   );

   acc_sync #(.WIDTH(3)) u_ext_sync (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .clk_en_in (clk_en_in),
      .d_in      ({hw_trigger_input_in, async_conv_clock_in, alternate_clock_in}),
      .q_out     (ext)
   );

   assign rise = ext & ~{r.hw_q, r.asy_q, r.alt_q};

   // ****************************************
   // converter clock: source select and divide
   // ****************************************
   // external clocks are sampled, so they must run well below the bus clock
   assign src_tick = (r.src == `ACC_SRC_BUS)  ? 1'b1 :     // R10 R23
                     (r.src == `ACC_SRC_BUS2) ? r.half :
                     (r.src == `ACC_SRC_ALT)  ? rise[0] : rise[1];

   acc_clk_div u_div (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .clk_en_in (clk_en_in),
      .clear_in  (r.state == ST_IDLE),
      .tick_in   (src_tick),
      .sel_in    (r.div),
      .tick_out  (conv_tick)
   );

   // ****************************************
   // bus decode: one wait state per access
   // ****************************************
   assign req   = avs_read_in | avs_write_in;
   assign acc   = req & ~r.wreq;
   assign wr    = acc & avs_write_in & avs_byteenable_in[0];
   assign rd    = acc & avs_read_in;
   assign wd    = avs_writedata_in[7:0];
   assign wsc1  = wr && (avs_address_in == `ACC_OFS_SC1);
   assign wsc2  = wr && (avs_address_in == `ACC_OFS_SC2);
   assign wcfg  = wr && (avs_address_in == `ACC_OFS_CFG);
   assign wcvh  = wr && (avs_address_in == `ACC_OFS_CVH);
   assign wcvl  = wr && (avs_address_in == `ACC_OFS_CVL);
   assign abort = wsc1 | wsc2 | wcfg | wcvh | wcvl; // R24

   // read mux; unmapped offsets read zero
   always_comb begin
      rmux = 8'h00;
      unique case (avs_address_in)
         `ACC_OFS_SC1: rmux = {r.done, r.ien, r.cont, r.ch};
         `ACC_OFS_SC2: rmux = {r.busy, r.hwsel, r.cfe, r.cgt, 4'h0};
         `ACC_OFS_RH:  rmux = r.rh;
         `ACC_OFS_RL:  rmux = r.rl;
         `ACC_OFS_CVH: rmux = {6'h00, r.cvh};
         `ACC_OFS_CVL: rmux = r.cvl;
         `ACC_OFS_CFG: rmux = {1'b0, r.div, 1'b0, r.mode, r.src};
         `ACC_OFS_PDL: rmux = r.pdis[7:0];
         `ACC_OFS_PDM: rmux = r.pdis[15:8];
         `ACC_OFS_PDH: rmux = r.pdis[23:16];
         default:      rmux = 8'h00;
      endcase
   end

   // ****************************************
   // result path: rounding, compare, blocking
   // ****************************************
   assign v10     = acc_round10(analog_value_in);                          // R6
   assign v8      = acc_round8(analog_value_in);                           // R7
   assign val     = (r.mode == `ACC_MODE_10) ? v10 : {2'h0, v8};           // R22
   assign cmpv    = (r.mode == `ACC_MODE_10) ? {r.cvh, r.cvl} : {2'h0, r.cvl};
   assign diff    = val - cmpv;
   assign cond    = r.cgt ? (val >= cmpv) : (val < cmpv);
   assign pass    = ~r.cfe | cond;                                          // R9
   assign blocked = (r.mode == `ACC_MODE_10) & r.rhpend;                    // R18
   assign need    = (r.mode == `ACC_MODE_10) ? TICKS_10 : TICKS_8;
   assign fin     = (r.state == ST_CONV) && conv_tick && (r.cnt == need - 6'h01);
   assign xfer    = fin & pass & ~blocked;                                  // R8
   // single with failed compare stops even if blocked; continuous, or passing but blocked, goes on
   assign restart = r.cont | (pass & blocked);                              // R17 R19 R20
   assign res16   = (r.mode == `ACC_MODE_10) ?                              // R6 R7
                    {6'h00, (r.cfe ? diff : v10)} : {8'h00, (r.cfe ? diff[7:0] : v8)};
   assign sw_start = wsc1 && !r.hwsel && (wd[4:0] != `ACC_CH_OFF);          // R16 R4
   // edges only count from idle, so continuous runs see the first one only
   assign hw_start = rise[2] && r.hwsel && (r.state == ST_IDLE)             // R13 R14 R15
                     && (r.ch != `ACC_CH_OFF) && !abort;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      n        = r;
      // bus handshake: drop waitrequest for one cycle per request
      n.wreq   = ~(req & r.wreq);
      if (req & r.wreq) begin
         n.rdata = rmux;
      end
      n.half   = ~r.half;
      {n.hw_q, n.asy_q, n.alt_q} = ext;
      // register writes
      if (wsc1) begin
         n.ien  = wd[`ACC_SC1_IEN];
         n.cont = wd[`ACC_SC1_CONT];
         n.ch   = wd[4:0];
         n.done = 1'b0;
         n.irq  = 1'b0;
      end
      if (wsc2) begin
         n.hwsel = wd[`ACC_SC2_HWT];
         n.cfe   = wd[`ACC_SC2_CFE];
         n.cgt   = wd[`ACC_SC2_CGT];
      end
      if (wcfg) begin
         n.div  = wd[`ACC_CFG_DIV +: 2];
         n.mode = wd[`ACC_CFG_MODE +: 2];
         n.src  = wd[`ACC_CFG_SRC +: 2];
      end
      if (wcvh) begin
         n.cvh = wd[1:0];
      end
      if (wcvl) begin
         n.cvl = wd;
      end
      if (wr && (avs_address_in == `ACC_OFS_PDL)) begin
         n.pdis[7:0] = wd;
      end
      if (wr && (avs_address_in == `ACC_OFS_PDM)) begin
         n.pdis[15:8] = wd;
      end
      if (wr && (avs_address_in == `ACC_OFS_PDH)) begin
         n.pdis[23:16] = wd;
      end
      // split read tracking; reading high arms the block
      if (rd && (avs_address_in == `ACC_OFS_RL)) begin
         n.rhpend = 1'b0;
      end
      if (rd && (avs_address_in == `ACC_OFS_RH)) begin
         n.rhpend = 1'b1; // R18
      end
      // result transfer; set beats a same-cycle clear
      if (xfer) begin
         {n.rh, n.rl} = res16;
         n.done       = 1'b1; // R8
         if (r.ien) begin
            n.irq = 1'b1; // R8
         end
      end
      // conversion sequencer
      unique case (r.state)
         ST_IDLE: begin
            if (sw_start || hw_start) begin
               n.state = ST_CONV;
               n.cnt   = 6'h00;
            end
         end
         ST_CONV: begin
            if (abort) begin
               n.state = sw_start ? ST_CONV : ST_IDLE; // R24 R16
               n.cnt   = 6'h00;
            end else if (fin) begin
               n.state = restart ? ST_CONV : ST_IDLE;  // R17 R19 R20 R5
               n.cnt   = 6'h00;
            end else if (conv_tick) begin
               n.cnt = r.cnt + 6'h01;
            end
         end
      endcase
      n.busy = (n.state == ST_CONV);                           // R4 R5
      n.aclk = n.busy && (n.src == `ACC_SRC_ASYNC);           // R11
      // pin control: disabled pins lose driver, pull-up and input
      n.oe  = port_oe_in & ~r.pdis;                            // R1 R2
      n.pu  = port_pullup_in & ~r.pdis;                        // R2
      n.prd = pin_q & ~r.pdis;                                 // R3
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r      <= '0;              // R4
         r.ch   <= `ACC_RST_CH;
         r.wreq <= 1'b1;
      end else if (clk_en_in) begin
         r <= n;
      end
   end

   assign avs_readdata_out     = {24'h000000, r.rdata};
   assign avs_waitrequest_out  = r.wreq;
   assign pad_oe_out           = r.oe;
   assign pad_pullup_out       = r.pu;
   assign port_read_out        = r.prd;
   assign channel_select_out   = r.ch;
   assign conv_active_out      = r.busy;
   assign async_clk_enable_out = r.aclk;
   assign conv_irq_out         = r.irq;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in || !clk_en_in);

   sequence s_sw_go;
      wsc1 && !r.hwsel && (wd[4:0] != `ACC_CH_OFF);
   endsequence

   sequence s_blk_go;
      fin && pass && blocked && !abort;
   endsequence

   AST_PIN_OFF: assert property (1'b1 |=> ((pad_oe_out | pad_pullup_out) & $past(r.pdis)) == 24'h0) // R2
      else $error("disabled pin still driven or pulled");
   AST_PIN_READ: assert property (1'b1 |=> (port_read_out & $past(r.pdis)) == 24'h0) // R3
      else $error("disabled pin reads nonzero");
   AST_CH_OFF: assert property (!r.busy && r.ch == `ACC_CH_OFF && !wsc1 |=> !conv_active_out) // R4
      else $error("converter woke with channel off");
   AST_IDLE: assert property (xfer && !r.cont && !abort |=> !conv_active_out && r.done) // R5
      else $error("converter not idle after single");
   AST_RES10: assert property (xfer && !r.cfe && r.mode == `ACC_MODE_10 |=> {r.rh[1:0], r.rl} == $past(v10)) // R6
      else $error("ten-bit result wrong");
   AST_RES8: assert property (xfer && !r.cfe && r.mode == `ACC_MODE_8 |=> r.rh == 8'h00 && r.rl == $past(v8)) // R7
      else $error("eight-bit result wrong");
   AST_IRQ: assert property (xfer && r.ien |=> conv_irq_out && r.done) // R8
      else $error("interrupt missing on done");
   AST_CMP_FAIL: assert property (fin && r.cfe && !cond |=> $stable({r.rh, r.rl})) // R9
      else $error("failed compare changed result");
   AST_HW_GO: assert property (hw_start |=> conv_active_out ##1 r.cnt == 6'h00 || conv_active_out) // R13
      else $error("hardware trigger did not start");
   AST_SW_GO: assert property (s_sw_go |=> conv_active_out) // R16
      else $error("software start missed");
   AST_BLOCK: assert property (s_blk_go |=> $stable({r.rh, r.rl}) && conv_active_out) // R18
      else $error("blocked transfer mishandled");
   AST_STOP: assert property (fin && r.cfe && !cond && !r.cont && !abort |=> !conv_active_out) // R19
      else $error("single failed compare kept converting");
   AST_CONT: assert property (xfer && r.cont && !abort |=> conv_active_out) // R17
      else $error("continuous did not restart");
   AST_ABORT: assert property (r.busy && (wsc2 || wcfg || wcvh || wcvl) |=> !conv_active_out) // R24
      else $error("write did not abort");
   AST_ASYNC: assert property (conv_active_out && r.src == `ACC_SRC_ASYNC |-> async_clk_enable_out) // R11
      else $error("async clock dropped while converting");
endmodule : acc_conv_ctrl

// *** design/acc_defs.svh ***
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
// ****************************************
// register byte offsets (one word each)
// ****************************************
`define ACC_AW          6
`define ACC_OFS_SC1     6'h00
`define ACC_OFS_SC2     6'h04
`define ACC_OFS_RH      6'h08
`define ACC_OFS_RL      6'h0c
`define ACC_OFS_CVH     6'h10
`define ACC_OFS_CVL     6'h14
`define ACC_OFS_CFG     6'h18
`define ACC_OFS_PDL     6'h1c
`define ACC_OFS_PDM     6'h20
`define ACC_OFS_PDH     6'h24
// ****************************************
// field positions
// ****************************************
`define ACC_SC1_DONE    7
`define ACC_SC1_IEN     6
`define ACC_SC1_CONT    5
`define ACC_SC2_ACT     7
`define ACC_SC2_HWT     6
`define ACC_SC2_CFE     5
`define ACC_SC2_CGT     4
`define ACC_CFG_DIV     5
`define ACC_CFG_MODE    2
`define ACC_CFG_SRC     0
// ****************************************
// codes, reset values, timing counts
// ****************************************
`define ACC_MODE_8      2'h0
`define ACC_MODE_10     2'h2
`define ACC_SRC_BUS     2'h0
`define ACC_SRC_BUS2    2'h1
`define ACC_SRC_ALT     2'h2
`define ACC_SRC_ASYNC   2'h3
`define ACC_CH_OFF      5'h1f
`define ACC_RST_CH      5'h1f
`define ACC_TICKS_8     6'h14
`define ACC_TICKS_10    6'h17
`endif

// *** design/acc_pkg.sv ***
package acc_pkg;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic {ST_IDLE, ST_CONV} acc_fsm_t;

   typedef struct packed {
      acc_fsm_t    state;   // conversion sequencer
      logic        busy;    // converter powered
      logic        aclk;    // async clock request
      logic        wreq;    // bus waitrequest
      logic [7:0]  rdata;   // latched read data
      logic [4:0]  ch;      // channel_select
      logic        ien;     // conv_irq_enable
      logic        cont;    // continuous_enable
      logic        done;    // conv_done_flag
      logic        irq;     // interrupt line
      logic        hwsel;   // hw_trigger_select
      logic        cfe;     // compare_enable
      logic        cgt;     // compare greater-or-equal
      logic [1:0]  cvh;     // compare_value_high
      logic [7:0]  cvl;     // compare_value_low
      logic [1:0]  div;     // clock_divide_select
      logic [1:0]  mode;    // conversion mode
      logic [1:0]  src;     // clock_source_select
      logic [7:0]  rh;      // result_high
      logic [7:0]  rl;      // result_low
      logic        rhpend;  // high read, low not yet
      logic [23:0] pdis;    // pin disable bits
      logic [23:0] oe;      // pad output enables
      logic [23:0] pu;      // pad pull-ups
      logic [23:0] prd;     // port read values
      logic        half;    // bus clock / 2 phase
      logic        alt_q;   // edge history
      logic        asy_q;
      logic        hw_q;
      logic [5:0]  cnt;     // converter clock count
   } acc_main_t;

   // ****************************************
   // rounding, saturating at full scale
   // ****************************************
   function automatic logic [9:0] acc_round10(input logic [10:0] raw);
      if (raw[10:1] == 10'h3ff) return 10'h3ff;
      return raw[10:1] + {9'h0, raw[0]};
   endfunction : acc_round10

   function automatic logic [7:0] acc_round8(input logic [10:0] raw);
      if (raw[10:3] == 8'hff) return 8'hff;
      return raw[10:3] + {7'h0, raw[2]};
   endfunction : acc_round8
endpackage : acc_pkg

// *** design/acc_sync.sv ***
`timescale 1ns/1ns
module acc_sync import acc_pkg::*; #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   input  wire logic             clk_en_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;  // metastable stage, read by s2 only
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;   // filtered level
   } acc_sync_t;

   acc_sync_t r;
   acc_sync_t n;

   // ****************************************
   // three stages; a change counts when s2 and s3 agree
   // ****************************************
   always_comb begin
      n    = r;
      n.s1 = d_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.q  = (r.s2 & r.s3) | (r.q & (r.s2 | r.s3));
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r <= '0;
      end else if (clk_en_in) begin
         r <= n;
      end
   end

   assign q_out = r.q;
endmodule : acc_sync

// *** tb/acc_far_model.sv ***
`timescale 1ns/1ns
// ****************************************
// far side: slow clock sources, trigger, analog core
// ****************************************
module acc_far_model (
   input  wire logic        clk_in,
   input  wire logic        trig_req_in,
   input  wire logic [10:0] level_in,
   output logic             alt_clk_out,
   output logic             async_clk_out,
   output logic             trig_out,
   output logic [10:0]      analog_out
);
   int phase = 0;  // free-running phase count
   // sources free-run at unrelated slow rates, so divider ticks are sparse
   always @(posedge clk_in) begin
      phase         <= phase + 1;
      alt_clk_out   <= (phase % 6) < 3;
      async_clk_out <= (phase % 10) < 5;
      trig_out      <= trig_req_in;
   end
   // raw approximation held steady for the whole conversion
   assign analog_out = level_in;
endmodule : acc_far_model

// *** tb/adc_conversion_control_tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module adc_conversion_control_tb import acc_pkg::*;;
   logic        clk_in = 0, srst_in = 1, rd = 0, wr = 0, treq = 0;
   logic [5:0]  addr = 0;
   logic [7:0]  wd = 0, q, hi;
   logic [10:0] lvl = 0, v, ana;
   logic [9:0]  e;
   logic [23:0] poe = 0, ppu = 0, pin = 0, dis, poe_o, ppu_o, prd_o;
   logic [31:0] rdat;
   logic        wreq, alt, asy, trg, act, aen, irq;
   logic [4:0]  chs;
   int          num_errors = 0, checks_done = 0;
   // ****************************************
   // design and far side
   // ****************************************
   acc_conv_ctrl #(.TICKS_8(6'h04), .TICKS_10(6'h04)) dut (.clk_in(clk_in), .srst_in(srst_in),
      .clk_en_in(1'b1), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in({24'h0, wd}), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .alternate_clock_in(alt), .async_conv_clock_in(asy),
      .hw_trigger_input_in(trg), .analog_value_in(ana), .port_oe_in(poe),
      .port_pullup_in(ppu), .pin_in(pin), .pad_oe_out(poe_o), .pad_pullup_out(ppu_o),
      .port_read_out(prd_o), .channel_select_out(chs), .conv_active_out(act),
      .async_clk_enable_out(aen), .conv_irq_out(irq));
   acc_far_model far (.clk_in(clk_in), .trig_req_in(treq), .level_in(lvl),
      .alt_clk_out(alt), .async_clk_out(asy), .trig_out(trg), .analog_out(ana));
   // clock, 4 ns period
   initial forever #2 clk_in = ~clk_in;
   // rounding expectations, saturating at full scale
   function automatic logic [9:0] exp10(input logic [10:0] r);
      return (r[10:1] == 10'h3ff) ? 10'h3ff : r[10:1] + {9'h0, r[0]};
   endfunction : exp10
   function automatic logic [9:0] exp8(input logic [10:0] r);
      return (r[10:3] == 8'hff) ? 10'h0ff : {2'h0, r[10:3] + {7'h0, r[2]}};
   endfunction : exp8
   // one bus access; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      addr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do begin
         @(posedge clk_in);
      end while (wreq !== 1'b0);
      q = rdat[7:0];
      wr <= 0;
      rd <= 0;
      @(posedge clk_in);
   endtask : bus
   // results are left alone until done shows, so only the blocked-transfer test gets a transfer blocked
   task automatic await_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      `CHK("irq", 1'b1, irq)
   endtask : await_irq
   task automatic wrap_up;
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // watchdog: 40000 cycles, far beyond the thousand or so cycles the tests need
   initial begin
      #160000;
      num_errors++;
      wrap_up;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'hb711));
      repeat (12) @(posedge clk_in);
      srst_in <= 0;
      bus(0, 6'h00, 8'h00);
      `CHK("ctl1", 8'h1f, q)
      bus(0, 6'h2c, 8'h00);
      `CHK("unmapped", 8'h00, q)
      poe <= $urandom;
      ppu <= $urandom;
      pin <= $urandom;
      dis = $urandom;
      bus(1, 6'h1c, dis[7:0]);
      bus(1, 6'h20, dis[15:8]);
      bus(1, 6'h24, dis[23:16]);
      repeat (8) @(posedge clk_in);
      `CHK("pad_oe", poe & ~dis, poe_o)
      `CHK("pullup", ppu & ~dis, ppu_o)
      `CHK("port_rd", pin & ~dis, prd_o)
      // every source code and divide code; odd codes run ten-bit
      for (int s = 0; s < 4; s++) begin
         v = $urandom;
         lvl <= v;
         bus(1, 6'h18, {1'b0, 2'(s), 1'b0, s[0] ? 2'h2 : 2'h0, 2'(s)});
         bus(1, 6'h00, 8'h43);
         @(posedge clk_in);
         `CHK("active", 1'b1, act)
         `CHK("async_en", s == 3, aen)
         await_irq;
         bus(0, 6'h08, 8'h00);
         hi = q;
         bus(0, 6'h0c, 8'h00);
         `CHK("result", s[0] ? exp10(v) : exp8(v), {hi[1:0], q})
      end
      // blocked transfer: high read, low not yet
      bus(1, 6'h18, 8'h08);
      v = $urandom;
      lvl <= v;
      bus(1, 6'h00, 8'h43);
      await_irq;
      e = exp10(v);
      bus(0, 6'h08, 8'h00);
      lvl <= 11'h7ff - v;
      bus(1, 6'h00, 8'h43);
      repeat (60) @(posedge clk_in);
      `CHK("blk_irq", 1'b0, irq)
      `CHK("blk_act", 1'b1, act)
      bus(0, 6'h0c, 8'h00);
      `CHK("old_low", e[7:0], q)
      await_irq;
      bus(0, 6'h08, 8'h00);
      hi = q;
      bus(0, 6'h0c, 8'h00);
      `CHK("new_res", exp10(11'h7ff - v), {hi[1:0], q})
      // hardware trigger: a software write alone must not start
      bus(1, 6'h04, 8'h40);
      bus(1, 6'h00, 8'h43);
      repeat (10) @(posedge clk_in);
      `CHK("hw_idle", 1'b0, act)
      treq <= 1;
      await_irq;
      treq <= 0;
      // compare on: a false single stops quietly, a true one stores the difference
      bus(1, 6'h04, 8'h20);
      bus(1, 6'h00, 8'h43);
      repeat (60) @(posedge clk_in);
      `CHK("cmp_stop", 1'b0, act)
      `CHK("cmp_irq", 1'b0, irq)
      v = $urandom;
      lvl <= v;
      e = exp10(v);
      bus(1, 6'h04, 8'h30);
      bus(1, 6'h14, e[9:2]);
      bus(1, 6'h00, 8'h43);
      await_irq;
      bus(0, 6'h08, 8'h00);
      hi = q;
      bus(0, 6'h0c, 8'h00);
      `CHK("cmp_res", e - {2'h0, e[9:2]}, {hi[1:0], q})
      // continuous runs on; a channel-off write stops it and keeps it off
      bus(1, 6'h04, 8'h00);
      bus(1, 6'h00, 8'h63);
      await_irq;
      `CHK("cont", 1'b1, act)
      bus(1, 6'h00, 8'h5f);
      repeat (10) @(posedge clk_in);
      `CHK("ch_off", 1'b0, act)
      `CHK("ch_sel", 5'h1f, chs)
      wrap_up;
   end
endmodule : adc_conversion_control_tb
